// >>> rtl/rps_pkg.sv
package rps_pkg;
  // ==========================================================
  // word layout, msb goes out first on lane 0
  // ==========================================================
  localparam int WORD_W    = 30;   // transmitted word width
  localparam int DATA_W    = 27;   // captured bits per pixel
  localparam int RGB_W     = 24;   // colour bits per pixel
  localparam int CTRL_W    = 3;    // vsync, hsync, data valid
  localparam int RSV_HI    = 29;   // upper reserved bit
  localparam int RSV_LO    = 28;   // lower reserved bit
  localparam int PAR_POS   = 27;   // odd parity bit
  localparam int RGB_LO    = 3;    // lowest colour bit in word
  localparam logic [1:0] RSV_VAL = 2'h0; // reserved bits value

  // ==========================================================
  // lane split
  // ==========================================================
  localparam int BITS_ONE  = 30;   // bits per word, one lane
  localparam int BITS_TWO  = 15;   // bits per lane, two lanes
  localparam int IDX_W     = 5;    // width of the bit index

  // ==========================================================
  // timing
  // ==========================================================
  localparam int CLK_PERIOD_NS = 8;     // 125 MHz system clock
  localparam int STOP_TIME_NS  = 1000;  // pixel clock silence
  localparam int STOP_CYC      = (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_EDGES    = 4;     // rising edges counted while locking
  localparam int BIT_DIV       = 2;     // clocks per serial bit

  // ==========================================================
  // power modes
  // ==========================================================
  typedef enum logic [1:0] {
    RPS_SHUTDOWN = 2'b00,
    RPS_STANDBY  = 2'b01,
    RPS_LOCKING  = 2'b10,
    RPS_ACTIVE   = 2'b11
  } rps_mode_t;
endpackage : rps_pkg

// >>> rtl/rps_pipe_buf.sv
`timescale 1ns/10ps
// two-entry buffer between capture and serializer
module rps_pipe_buf #(
  parameter int W = 30  // word width
) (
  input  wire logic         clk_in,    // system clock
  input  wire logic         rst_n_in,  // synced reset, low active
  input  wire logic         flush_in,  // drop all entries
  input  wire logic         s_valid_in, // word offered
  output logic              s_ready_out, // room for a word
  input  wire logic [W-1:0] s_data_in, // word in
  output logic              m_valid_out, // word held
  input  wire logic         m_ready_in, // consumer takes
  output logic [W-1:0]      m_data_out // oldest word
);
  logic [W-1:0] mem [2];  // storage
  logic         wp;       // write slot
  logic         rp;       // read slot
  logic [1:0]   fill;     // entries held

  wire push = s_valid_in && (fill != 2'h2);  // accepted word
  wire pop  = m_ready_in && (fill != 2'h0);  // consumed word

  assign s_ready_out = (fill != 2'h2);
  assign m_valid_out = (fill != 2'h0);
  assign m_data_out  = mem[rp];

  // ==========================================================
  // pointers and fill level
  // ==========================================================
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp   <= 1'b0;
      rp   <= 1'b0;
      fill <= 2'h0;
    end else if (flush_in) begin
      // leaving active mode discards stale pixels
      wp   <= 1'b0;
      rp   <= 1'b0;
      fill <= 2'h0;
    end else begin
      if (push) wp <= ~wp;
      if (pop) rp <= ~rp;
      fill <= fill + {1'b0, push} - {1'b0, pop};
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_in) begin
    if (push) mem[wp] <= s_data_in;
  end
endmodule : rps_pipe_buf

// >>> rtl/rps_shifter.sv
`timescale 1ns/10ps
// word serializer with forwarded pixel clock
module rps_shifter
  import rps_pkg::*;
(
  input  wire logic              clk_in,     // system clock
  input  wire logic              rst_n_in,   // synced reset
  input  wire logic              enable_in,  // active mode
  input  wire logic              two_lane_in, // two lanes used
  input  wire logic              bit_en_in,  // one serial bit time
  input  wire logic              w_valid_in, // word available
  output logic                   w_ready_out, // word taken
  input  wire logic [WORD_W-1:0] w_data_in,  // word to send
  output logic                   lane0_out,  // lane 0 bit
  output logic                   lane1_out,  // lane 1 bit
  output logic                   fclk_out    // forwarded clock
);
  logic [WORD_W-1:0] sh;    // shift register
  logic [IDX_W-1:0]  idx;   // bit index in lane
  logic              busy;  // word in flight
  logic [IDX_W-1:0]  last;  // final index

  assign last = two_lane_in ? IDX_W'(BITS_TWO - 1) : IDX_W'(BITS_ONE - 1);
  assign w_ready_out = enable_in && bit_en_in && (!busy || idx == last);

  // ==========================================================
  // shift engine
  // ==========================================================
  // R6 lane rate split
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sh   <= '0;
      idx  <= '0;
      busy <= 1'b0;
    end else if (!enable_in) begin
      busy <= 1'b0;
      idx  <= '0;
    end else if (bit_en_in) begin
      if (w_ready_out && w_valid_in) begin
        sh   <= w_data_in;
        idx  <= '0;
        busy <= 1'b1;
      end else if (busy && idx == last) begin
        busy <= 1'b0;
      end else if (busy) begin
        idx <= idx + 1'b1;
        // two lanes shift their halves side by side
        sh  <= two_lane_in ? {sh[28:15], 1'b0, sh[13:0], 1'b0} : {sh[28:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // line outputs, registered
  // ==========================================================
  // R8 regenerated pixel clock
  // R17 fixed clock polarity
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lane0_out <= 1'b0;
      lane1_out <= 1'b0;
      fclk_out  <= 1'b0;
    end else begin
      lane0_out <= busy && sh[WORD_W-1];
      lane1_out <= busy && two_lane_in && sh[BITS_TWO-1];
      // high in the first half of every word
      fclk_out  <= busy && (idx <= (last >> 1));
    end
  end

  // R11 silent when not active
  a_idle_silent: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !enable_in |=> ##1 !lane0_out && !fclk_out) else $error("line toggles outside active");
  // R17 clock high at word start
  a_fclk_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    busy && idx == '0 |=> fclk_out) else $error("forwarded clock low at word start");
endmodule : rps_shifter

// >>> rtl/rps_serializer.sv
`timescale 1ns/10ps
// What this block does
// R1 - 27 parallel bits out on lanes
// R2 - load rgb and three control bits
// R3 - add parity, two reserved, 30 bits
// R4 - parity is odd over word
// R5 - one word per pixel clock period
// R6 - shift 30 bits one lane, 15 two
// R7 - lock to pixel clock before sending
// R8 - forward regenerated pixel clock
// R9 - edge select picks rising or falling
// R10 - pixel clock stop enters standby
// R11 - shutdown, standby, active; send only active
// R12 - transmit enable low means shutdown
// R13 - link count chooses one or two lanes
// R14 - bus order high reverses colour bits
// R15 - host keeps pixel clock 4 to 30 MHz
// R16 - lane 1 driven only with two lanes
// R17 - forwarded clock polarity is fixed
// R18 - reserved bits zero, fixed word layout
module rps_serializer
  import rps_pkg::*;
#(
  parameter int STOP_CYCLES = STOP_CYC,   // pixel clock silence
  parameter int LOCK_COUNT  = LOCK_EDGES, // edges to lock
  parameter int BIT_CLKS    = BIT_DIV     // clocks per bit
) (
  input  wire logic              clk_in,          // 125 MHz
  input  wire logic              rstn_in,         // async reset
  input  wire logic              pclk_in,         // pixel clock pin
  input  wire logic [RGB_W-1:0]  pixel_bus_in,    // colour pins
  input  wire logic              vertical_sync_in, // frame sync
  input  wire logic              horizontal_sync_in, // line sync
  input  wire logic              pixel_data_valid_in, // valid
  input  wire logic              latch_edge_select_in, // 1 fall
  input  wire logic              bus_order_in,    // 1 reversed
  input  wire logic              link_count_select_in, // 1 two
  input  wire logic              transmit_enable_in, // 0 off
  output logic                   serial_lane_0_out, // lane 0
  output logic                   serial_lane_1_out, // lane 1
  output logic                   serial_lane_1_oe_out, // drive
  output logic                   fwd_clk_out,     // clock copy
  output rps_pkg::rps_mode_t     mode_out,        // power mode
  output logic                   overrun_out      // word lost
);
  import rps_pkg::*;

  // ==========================================================
  // helpers
  // ==========================================================
  // R14 full bit reversal
  function automatic logic [RGB_W-1:0] rps_rev(input logic [RGB_W-1:0] v);
    logic [RGB_W-1:0] r;
    r = '0;
    for (int i = 0; i < RGB_W; i++) r[i] = v[RGB_W-1-i];
    return r;
  endfunction : rps_rev

  // R4 odd parity over the data
  function automatic logic rps_par(input logic [DATA_W-1:0] d);
    return ~(^d);
  endfunction : rps_par

  // ==========================================================
  // reset release
  // ==========================================================
  logic rst_s1;  // first stage
  logic rst_n;   // released reset

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  localparam int PIN_W = DATA_W + 5;  // all sampled pins
  logic [PIN_W-1:0] pin_s1;  // first stage
  logic [PIN_W-1:0] pin_s2;  // second stage
  logic             pclk_d;  // delayed pixel clock

  // data pins travel with the clock so they stay aligned
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pclk_d <= 1'b0;
    end else begin
      pin_s1 <= {pclk_in, latch_edge_select_in, bus_order_in, link_count_select_in,
                 transmit_enable_in, pixel_bus_in, vertical_sync_in,
                 horizontal_sync_in, pixel_data_valid_in};
      pin_s2 <= pin_s1;
      pclk_d <= pin_s2[PIN_W-1];
    end
  end

  logic             pclk_s;     // synced pixel clock
  logic             fall_sel;   // synced edge select
  logic             rev_sel;    // synced bus order
  logic             two_lane;   // synced link count
  logic             tx_enable_s; // synced transmit enable
  logic [RGB_W-1:0] rgb_s;      // synced colour bits
  logic [2:0]       ctrl_s;     // synced syncs and data valid

  assign pclk_s   = pin_s2[PIN_W-1];
  assign fall_sel = pin_s2[PIN_W-2];
  assign rev_sel  = pin_s2[PIN_W-3];
  assign two_lane = pin_s2[PIN_W-4];
  assign tx_enable_s = pin_s2[PIN_W-5];
  assign rgb_s    = pin_s2[DATA_W-1:CTRL_W];
  assign ctrl_s   = pin_s2[CTRL_W-1:0];

  // edges of the synced pixel clock
  wire rise = pclk_s && !pclk_d;  // rising edge seen
  wire fall = !pclk_s && pclk_d;  // falling edge seen
  // R9 latch edge chooser
  wire latch = fall_sel ? fall : rise;

  // ==========================================================
  // clock presence timer
  // ==========================================================
  logic [15:0] quiet;  // cycles since last edge
  wire stopped = (quiet == 16'(STOP_CYCLES - 1));

  // R10 detect stopped pixel clock
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      quiet <= '0;
    end else if (rise || fall) begin
      quiet <= '0;
    end else if (!stopped) begin
      quiet <= quiet + 16'h1;
    end
  end

  // ==========================================================
  // power mode machine
  // ==========================================================
  rps_mode_t  mode;        // current mode
  rps_mode_t  next_mode;   // following mode
  logic [7:0] lock_cnt;    // edges seen while locking

  // R11 four power modes, locking between standby and active
  always_comb begin
    next_mode = mode;
    case (mode)
      RPS_SHUTDOWN: begin
        if (tx_enable_s) next_mode = RPS_STANDBY;
      end
      RPS_STANDBY: begin
        if (rise) next_mode = RPS_LOCKING;
      end
      RPS_LOCKING: begin
        // R7 wait for LOCK_COUNT rising edges to lock
        if (stopped) next_mode = RPS_STANDBY;
        else if (rise && lock_cnt == 8'(LOCK_COUNT - 1)) next_mode = RPS_ACTIVE;
      end
      RPS_ACTIVE: begin
        // R10 clock stop to standby
        if (stopped) next_mode = RPS_STANDBY;
      end
      default: next_mode = RPS_SHUTDOWN;
    endcase
    // R12 enable low forces shutdown
    if (!tx_enable_s) next_mode = RPS_SHUTDOWN;
  end

  // mode register
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mode <= RPS_SHUTDOWN;
    end else begin
      mode <= next_mode;
    end
  end

  // lock counter counts edges after the first one
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt <= '0;
    end else if (mode != RPS_LOCKING) begin
      lock_cnt <= '0;
    end else if (rise) begin
      lock_cnt <= lock_cnt + 8'h1;
    end
  end

  wire active = (mode == RPS_ACTIVE);  // transmitting

  // ==========================================================
  // word capture
  // ==========================================================
  logic [WORD_W-1:0] cap_word;   // assembled word
  logic              cap_valid;  // word waiting for buffer
  logic              buf_ready;  // buffer has room
  logic [RGB_W-1:0]  rgb_ord;    // colour bits in fixed order
  logic [DATA_W-1:0] data27;     // captured bits

  // R14 undo the reversed bus
  assign rgb_ord = rev_sel ? rps_rev(rgb_s) : rgb_s;
  // R2 colour plus control bits
  assign data27  = {rgb_ord, ctrl_s};

  // R5 one word per pixel period
  // R3 thirty bit word
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cap_word  <= '0;
      cap_valid <= 1'b0;
    end else if (!active) begin
      cap_valid <= 1'b0;
    end else if (latch) begin
      // R18 reserved bits fixed
      cap_word  <= {RSV_VAL, rps_par(data27), data27};
      cap_valid <= 1'b1;
    end else if (buf_ready) begin
      cap_valid <= 1'b0;
    end
  end

  // a new edge while the last word still waits on a full buffer drops a word
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      overrun_out <= 1'b0;
    end else if (!active) begin
      overrun_out <= 1'b0;
    end else if (latch && cap_valid && !buf_ready) begin
      overrun_out <= 1'b1;
    end
  end

  // ==========================================================
  // bit rate divider
  // ==========================================================
  logic [7:0] div_cnt;  // clocks into bit time
  logic       bit_en;   // one cycle per serial bit

  // R7 serial bit clock enable
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
      bit_en  <= 1'b0;
    end else if (!active || div_cnt == 8'(BIT_CLKS - 1)) begin
      div_cnt <= '0;
      bit_en  <= active;
    end else begin
      div_cnt <= div_cnt + 8'h1;
      bit_en  <= 1'b0;
    end
  end

  // ==========================================================
  // buffer and serializer
  // ==========================================================
  logic              q_valid;  // buffered word present
  logic              q_ready;  // serializer takes word
  logic [WORD_W-1:0] q_data;   // buffered word
  logic              lane0;    // lane 0 from shifter
  logic              lane1;    // lane 1 from shifter
  logic              fclk;     // clock from shifter

  rps_pipe_buf #(
    .W (WORD_W)
  ) u_buf (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n),
    .flush_in    (!active),
    .s_valid_in  (cap_valid),
    .s_ready_out (buf_ready),
    .s_data_in   (cap_word),
    .m_valid_out (q_valid),
    .m_ready_in  (q_ready),
    .m_data_out  (q_data)
  );

  // R1 serial lanes
  // R13 lane count select
  rps_shifter u_shift (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n),
    .enable_in   (active),
    .two_lane_in (two_lane),
    .bit_en_in   (bit_en),
    .w_valid_in  (q_valid),
    .w_ready_out (q_ready),
    .w_data_in   (q_data),
    .lane0_out   (lane0),
    .lane1_out   (lane1),
    .fclk_out    (fclk)
  );

  // ==========================================================
  // registered outputs
  // ==========================================================
  // R16 lane 1 drive enable
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      serial_lane_0_out    <= 1'b0;
      serial_lane_1_out    <= 1'b0;
      serial_lane_1_oe_out <= 1'b0;
      fwd_clk_out          <= 1'b0;
      mode_out             <= RPS_SHUTDOWN;
    end else begin
      serial_lane_0_out    <= lane0;
      serial_lane_1_out    <= lane1;
      serial_lane_1_oe_out <= active && two_lane;
      fwd_clk_out          <= fclk;
      mode_out             <= mode;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  a_parity_odd: assert property (@(posedge clk_in) disable iff (!rst_n) // R4
    $rose(cap_valid) |-> ^cap_word[DATA_W:0]) else $error("parity not odd");
  a_reserved_zero: assert property (@(posedge clk_in) disable iff (!rst_n) // R18
    cap_valid |-> cap_word[RSV_HI:RSV_LO] == RSV_VAL) else $error("reserved bits set");
  a_shutdown_entry: assert property (@(posedge clk_in) disable iff (!rst_n) // R12
    !tx_enable_s |=> mode == RPS_SHUTDOWN ##1 mode_out == RPS_SHUTDOWN) else $error("no shutdown");
  a_stop_standby: assert property (@(posedge clk_in) disable iff (!rst_n) // R10
    active && stopped && tx_enable_s |=> mode == RPS_STANDBY) else $error("no standby on stop");
  a_capture_edge: assert property (@(posedge clk_in) disable iff (!rst_n) // R5
    active && latch && tx_enable_s && !stopped |=> cap_valid && cap_word[DATA_W-1:0] == $past(data27))
    else $error("edge not captured");
  a_swap_order: assert property (@(posedge clk_in) disable iff (!rst_n) // R14
    active && latch && rev_sel |=> cap_word[DATA_W-1:RGB_LO] == rps_rev($past(rgb_s)))
    else $error("bus order wrong");
  a_lane1_release: assert property (@(posedge clk_in) disable iff (!rst_n) // R16
    !two_lane |=> !serial_lane_1_oe_out) else $error("lane 1 driven in one lane mode");
  a_active_only: assert property (@(posedge clk_in) disable iff (!rst_n) // R11
    !active |=> !cap_valid && !q_ready) else $error("transfer outside active");
  a_lock_needed: assert property (@(posedge clk_in) disable iff (!rst_n) // R7
    mode == RPS_STANDBY |=> mode != RPS_ACTIVE) else $error("active without lock");
endmodule : rps_serializer

// >>> dv/rps_rx_model.sv
`timescale 1ns/10ps
// ==========================================
// receiver model: rebuilds words from lanes
module rps_rx_model
  import rps_pkg::*;
#(
  parameter int BIT_CLKS = BIT_DIV  // clocks per bit
) (
  input  wire logic         clk_in,         // system clock
  input  wire logic         two_lane_in,    // two lanes used
  input  wire logic         lane0_in,       // lane 0 wire
  input  wire logic         lane1_in,       // lane 1 wire
  input  wire logic         fclk_in,        // forwarded clock
  output logic [WORD_W-1:0] word_out,       // rebuilt word
  output logic              word_valid_out  // one-cycle done
);
  logic fclk_d = 1'b0;  // last clock level
  int   idx    = -1;    // bit index, idle below zero
  int   ph     = 0;     // clocks into the bit
  always @(posedge clk_in) begin
    word_valid_out <= 1'b0;
    fclk_d <= fclk_in;
    if (idx < 0 && fclk_in && !fclk_d) begin
      idx = 0;
      ph = 0;
    end
    if (idx >= 0) begin
      // sample in the first clock of each bit
      if (ph == 0) begin
        word_out[WORD_W-1-idx] <= lane0_in;
        if (two_lane_in) word_out[BITS_TWO-1-idx] <= lane1_in;
      end
      ph = ph + 1;
      if (ph == BIT_CLKS) begin
        ph = 0;
        idx = idx + 1;
      end
      if (idx == (two_lane_in ? BITS_TWO : BITS_ONE)) begin
        idx = -1;
        word_valid_out <= 1'b1;
      end
    end
  end
endmodule : rps_rx_model

// >>> dv/rps_serializer_test.sv
`timescale 1ns/10ps
module rps_serializer_test;
  import rps_pkg::*;
  localparam int H = 80;  // pixel period in clocks, slow on purpose
  logic              clk_in = 0;    // 125 MHz
  logic              rstn_in = 0;   // reset, low active
  logic              pclk = 0;      // pixel clock
  logic [26:0]       pix = '0;      // colour bus and control
  logic              edge_sel = 0;  // 1 falling edge
  logic              order = 0;     // 1 reversed bus
  logic              two = 0;       // 1 two lanes
  logic              tx_on = 1;     // 0 shutdown
  logic              lane0, lane1, oe, fclk, ovr;
  wire               lane1_w = oe ? lane1 : 1'bz;  // released lane floats
  rps_mode_t         mode;
  logic [WORD_W-1:0] rx_w;
  logic              rx_v;
  logic [WORD_W-1:0] rx_q[$], exp_q[$];
  int                n_fail = 0, checked = 0, cyc = 0;

  rps_serializer #(.STOP_CYCLES(125), .LOCK_COUNT(1), .BIT_CLKS(2)) dut_u (
    .clk_in(clk_in), .rstn_in(rstn_in), .pclk_in(pclk), .pixel_bus_in(pix[26:3]),
    .vertical_sync_in(pix[2]), .horizontal_sync_in(pix[1]), .pixel_data_valid_in(pix[0]),
    .latch_edge_select_in(edge_sel), .bus_order_in(order), .link_count_select_in(two),
    .transmit_enable_in(tx_on), .serial_lane_0_out(lane0), .serial_lane_1_out(lane1),
    .serial_lane_1_oe_out(oe), .fwd_clk_out(fclk), .mode_out(mode), .overrun_out(ovr));
  rps_rx_model #(.BIT_CLKS(2)) rx_u (.clk_in(clk_in), .two_lane_in(two), .lane0_in(lane0),
    .lane1_in(lane1_w), .fclk_in(fclk), .word_out(rx_w), .word_valid_out(rx_v));

  // ==========================================
  // clock, timeout, received words
  initial forever #4 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (rx_v === 1'b1) rx_q.push_back(rx_w);
    // the whole run needs well under this many clocks
    if (cyc == 20000) begin
      n_fail++;
      $display("BAD %0t timeout", $time);
      end_of_test();
    end
  end

  // ==========================================
  // compare and drive helpers
  task automatic chkb(input logic a, input logic e);
    checked++;
    if (a !== e) begin
      n_fail++;
      $display("BAD %0t bit %b want %b", $time, a, e);
    end
  endtask : chkb
  task automatic chkm(input rps_mode_t a, input rps_mode_t e);
    checked++;
    if (a !== e) begin
      n_fail++;
      $display("BAD %0t mode %b want %b", $time, a, e);
    end
  endtask : chkm
  task automatic chkw(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] e);
    checked++;
    if (a !== e) begin
      n_fail++;
      $display("BAD %0t word %h want %h", $time, a, e);
    end
  endtask : chkw
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wait_clk
  // first half shows a, second half b: rise sees a, fall sees b
  task automatic pix_one(input logic [26:0] a, input logic [26:0] b, input int hp);
    pix <= a;
    wait_clk(hp / 4);
    pclk <= 1'b1;
    wait_clk(hp / 4);
    pix <= b;
    wait_clk(hp / 4);
    pclk <= 1'b0;
    wait_clk(hp / 4);
  endtask : pix_one
  function automatic logic [WORD_W-1:0] exp_w(input logic [26:0] v);
    logic [23:0] rgb;
    rgb = order ? {<<{v[26:3]}} : v[26:3];
    return {2'h0, ~^{rgb, v[2:0]}, rgb, v[2:0]};
  endfunction : exp_w
  task automatic wake();
    for (int n = 0; n < 10 && mode !== RPS_ACTIVE; n++) pix_one(27'h0, 27'h0, H);
    chkm(mode, RPS_ACTIVE);
    wait_clk(80);
    rx_q.delete();
    exp_q.delete();
  endtask : wake
  task automatic burst();
    logic [26:0] pat[5] = '{27'h0, 27'h7FFFFFF, 27'h5A5A5A5, 27'h1234567, 27'h4000001};
    wake();
    foreach (pat[k]) begin
      exp_q.push_back(exp_w(edge_sel ? ~pat[k] : pat[k]));
      pix_one(pat[k], ~pat[k], H);
    end
    chkb(ovr, 1'b0);
    chkb(oe, two);
    wait_clk(200);
    chkm(mode, RPS_STANDBY);
    chkb(oe, 1'b0);
    chkb(rx_q.size() == exp_q.size(), 1'b1);
    foreach (exp_q[k]) chkw(rx_q[k], exp_q[k]);
  endtask : burst

  // ==========================================
  // scenarios
  task automatic t_shutdown();
    tx_on <= 1'b0;
    wait_clk(8);
    chkm(mode, RPS_SHUTDOWN);
    repeat (3) pix_one(27'h7FFFFFF, 27'h0, H);
    chkb(rx_q.size() == 0, 1'b1);
    chkb(fclk, 1'b0);
    tx_on <= 1'b1;
    wait_clk(8);
    chkm(mode, RPS_STANDBY);
  endtask : t_shutdown
  task automatic t_one_lane_rise();
    two <= 1'b0;
    edge_sel <= 1'b0;
    order <= 1'b0;
    burst();
  endtask : t_one_lane_rise
  task automatic t_two_lane_fall();
    two <= 1'b1;
    edge_sel <= 1'b1;
    order <= 1'b1;
    burst();
  endtask : t_two_lane_fall
  task automatic t_one_lane_fall_rev();
    two <= 1'b0;
    edge_sel <= 1'b1;
    order <= 1'b1;
    burst();
  endtask : t_one_lane_fall_rev
  // pixel clock far too fast: the buffer must refuse and flag it
  task automatic t_overrun();
    two <= 1'b0;
    edge_sel <= 1'b0;
    wake();
    repeat (8) pix_one(27'h1234567, 27'h0, 8);
    chkb(ovr, 1'b1);
    wait_clk(200);
    chkb(ovr, 1'b0);
  endtask : t_overrun

  task automatic end_of_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    wait_clk(10);
    chkm(mode, RPS_STANDBY);
    t_shutdown();
    t_one_lane_rise();
    t_two_lane_fall();
    t_one_lane_fall_rev();
    t_overrun();
    end_of_test();
  end
endmodule : rps_serializer_test
